// >>> dac_pd_pkg.sv
`default_nettype none
package dac_pd_pkg;
	// core clock and wake-up interval
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned WAKE_TIME_NS = 800;
	localparam int unsigned WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] WAKE_CNT_INIT = 5'(WAKE_CYCLES);
	localparam logic [4:0] WAKE_CNT_LAST = 5'h01;

	// serial bus
	localparam logic [6:0] BROADCAST_ADDR = 7'h48;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam int unsigned BYTE_W = 8;

	// register word layout
	localparam int unsigned WORD_MSB = 15;
	localparam int unsigned PD_HI_BIT = 13;
	localparam int unsigned PD_LO_BIT = 12;
	localparam int unsigned CODE_MSB = 11;
	localparam int unsigned CODE_LSB = 2;
	localparam logic [15:0] RESET_WORD = 16'h0000;

	// power-down select encodings
	localparam logic [1:0] PD_NORMAL = 2'h0;
	localparam logic [1:0] PD_LOAD_2K5 = 2'h1;
	localparam logic [1:0] PD_LOAD_100K = 2'h2;
	localparam logic [1:0] PD_HIGH_Z = 2'h3;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_ACK_ADDR = 7'h04,
		ST_WR_BYTE = 7'h08,
		ST_ACK_WR = 7'h10,
		ST_RD_BYTE = 7'h20,
		ST_ACK_RD = 7'h40
	} bus_state_t;

	typedef struct packed {
		logic [9:0] analog_output_level;
		logic pwrdn_select_hi;
		logic pwrdn_select_lo;
		logic bias_en;
		logic amp_en;
		logic string_en;
		logic linear_en;
		logic term_high_z;
		logic term_2k5;
		logic term_100k;
		logic output_valid;
	} analog_ctrl_t;

	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_d;
		logic sda_s1;
		logic sda_s2;
		logic sda_d;
		bus_state_t st;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic [7:0] hi_byte;
		logic byte_hi;
		logic rw;
		logic master_ack;
		logic sda_oe_n;
		logic sda_out;
		logic [15:0] word;
		logic wr_commit;
		logic [4:0] wake_cnt;
		analog_ctrl_t ctrl;
	} core_state_t;

	localparam analog_ctrl_t CTRL_RESET = '{bias_en: 1'b1, amp_en: 1'b1, string_en: 1'b1,
		linear_en: 1'b1, output_valid: 1'b1, default: '0};
	localparam core_state_t CORE_RESET = '{scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
		sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1, st: ST_IDLE, sda_oe_n: 1'b1,
		word: RESET_WORD, ctrl: CTRL_RESET, default: '0};
endpackage
`default_nettype wire

// >>> dac_power_down_control.sv
// Overview of operation
// - a completed write with either power-down bit set enters power-down
// - power-down bits pick high impedance, 2.5k or 100k load to ground
// - any power-down mode turns off bias, amplifier, string and linear enables
// - the full written word including power-down bits is kept in power-down
// - reads during power-down still return the stored word
// - leaving power-down stores the new word and drives its 10-bit code
// - output is flagged valid only after the wake-up interval
// - data line is driven only for own acknowledge or read data bits
// - word holds two zero bits, two mode bits, then data msb first
// - a written word takes effect at the acknowledge after the lower byte
// - reset clears the whole word so the output starts at zero
`timescale 1ns/1ps
`default_nettype none
module dac_power_down_control #(
	parameter logic [6:0] SLAVE_ADDR = 7'h2a
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// two-wire bus pins
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe_n,
	// analog control
	output dac_pd_pkg::analog_ctrl_t o_ctrl
);
	dac_pd_pkg::core_state_t cur;
	dac_pd_pkg::core_state_t next_cur;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic [1:0] new_pd;
	// edges only from the second sync stage and its delayed copy
	assign scl_rise = cur.scl_s2 & ~cur.scl_d;
	assign scl_fall = ~cur.scl_s2 & cur.scl_d;
	assign bus_start = cur.scl_s2 & cur.scl_d & cur.sda_d & ~cur.sda_s2;
	assign bus_stop = cur.scl_s2 & cur.scl_d & ~cur.sda_d & cur.sda_s2;
	function automatic logic addr_hit(input logic [6:0] addr, input logic rd);
		addr_hit = (addr == SLAVE_ADDR) || ((addr == dac_pd_pkg::BROADCAST_ADDR) && !rd);
	endfunction
	always_comb
	begin
		next_cur = cur;
		next_cur.scl_s1 = i_scl;
		next_cur.scl_s2 = cur.scl_s1;
		next_cur.scl_d = cur.scl_s2;
		next_cur.sda_s1 = i_sda;
		next_cur.sda_s2 = cur.sda_s1;
		next_cur.sda_d = cur.sda_s2;
		next_cur.wr_commit = 1'b0;
		next_cur.sda_out = 1'b0;
		if (bus_start)
		begin
			next_cur.st = dac_pd_pkg::ST_ADDR;
			next_cur.bit_cnt = '0;
			next_cur.sda_oe_n = 1'b1;
		end
		else if (bus_stop)
		begin
			next_cur.st = dac_pd_pkg::ST_IDLE;
			next_cur.sda_oe_n = 1'b1;
		end
		else
		begin
			case (cur.st)
				dac_pd_pkg::ST_ADDR:
				begin
					if (scl_rise)
					begin
						next_cur.shift = {cur.shift[6:0], cur.sda_s2};
						next_cur.bit_cnt = cur.bit_cnt + 4'h1;
					end
					else if (scl_fall && cur.bit_cnt == dac_pd_pkg::BYTE_BITS)
					begin
						next_cur.rw = cur.shift[0];
						// unmatched address, including a high-speed master code, gets no acknowledge
						if (addr_hit(cur.shift[7:1], cur.shift[0]))
						begin
							next_cur.st = dac_pd_pkg::ST_ACK_ADDR;
							next_cur.sda_oe_n = 1'b0;
						end
						else
						begin
							next_cur.st = dac_pd_pkg::ST_IDLE;
						end
					end
				end
				dac_pd_pkg::ST_ACK_ADDR:
				begin
					if (scl_fall)
					begin
						next_cur.bit_cnt = '0;
						next_cur.byte_hi = 1'b1;
						if (cur.rw)
						begin
							next_cur.st = dac_pd_pkg::ST_RD_BYTE;
							next_cur.shift = cur.word[dac_pd_pkg::WORD_MSB -: dac_pd_pkg::BYTE_W];
							next_cur.sda_oe_n = cur.word[dac_pd_pkg::WORD_MSB];
						end
						else
						begin
							next_cur.st = dac_pd_pkg::ST_WR_BYTE;
							next_cur.sda_oe_n = 1'b1;
						end
					end
				end
				dac_pd_pkg::ST_WR_BYTE:
				begin
					if (scl_rise)
					begin
						next_cur.shift = {cur.shift[6:0], cur.sda_s2};
						next_cur.bit_cnt = cur.bit_cnt + 4'h1;
					end
					else if (scl_fall && cur.bit_cnt == dac_pd_pkg::BYTE_BITS)
					begin
						next_cur.st = dac_pd_pkg::ST_ACK_WR;
						next_cur.sda_oe_n = 1'b0;
						if (cur.byte_hi)
						begin
							next_cur.hi_byte = cur.shift;
						end
					end
				end
				dac_pd_pkg::ST_ACK_WR:
				begin
					if (scl_rise && !cur.byte_hi)
					begin
						next_cur.word = {cur.hi_byte, cur.shift};
						next_cur.wr_commit = 1'b1;
					end
					else if (scl_fall)
					begin
						// master may stream further words without a new address
						next_cur.st = dac_pd_pkg::ST_WR_BYTE;
						next_cur.sda_oe_n = 1'b1;
						next_cur.bit_cnt = '0;
						next_cur.byte_hi = ~cur.byte_hi;
					end
				end
				dac_pd_pkg::ST_RD_BYTE:
				begin
					if (scl_rise)
					begin
						next_cur.bit_cnt = cur.bit_cnt + 4'h1;
					end
					else if (scl_fall)
					begin
						if (cur.bit_cnt == dac_pd_pkg::BYTE_BITS)
						begin
							next_cur.st = dac_pd_pkg::ST_ACK_RD;
							next_cur.sda_oe_n = 1'b1;
						end
						else
						begin
							next_cur.shift = {cur.shift[6:0], 1'b0};
							next_cur.sda_oe_n = cur.shift[6];
						end
					end
				end
				dac_pd_pkg::ST_ACK_RD:
				begin
					if (scl_rise)
					begin
						next_cur.master_ack = ~cur.sda_s2;
					end
					else if (scl_fall)
					begin
						if (cur.master_ack)
						begin
							next_cur.st = dac_pd_pkg::ST_RD_BYTE;
							next_cur.bit_cnt = '0;
							next_cur.byte_hi = ~cur.byte_hi;
							if (cur.byte_hi)
							begin
								next_cur.shift = cur.word[dac_pd_pkg::BYTE_W-1:0];
								next_cur.sda_oe_n = cur.word[dac_pd_pkg::BYTE_W-1];
							end
							else
							begin
								next_cur.shift = cur.word[dac_pd_pkg::WORD_MSB -: dac_pd_pkg::BYTE_W];
								next_cur.sda_oe_n = cur.word[dac_pd_pkg::WORD_MSB];
							end
						end
						else
						begin
							next_cur.st = dac_pd_pkg::ST_IDLE;
						end
					end
				end
				default:
				begin
					next_cur.st = dac_pd_pkg::ST_IDLE;
					next_cur.sda_oe_n = 1'b1;
				end
			endcase
		end

		if (cur.wake_cnt != '0)
		begin
			next_cur.wake_cnt = cur.wake_cnt - 5'h01;
			if (cur.wake_cnt == dac_pd_pkg::WAKE_CNT_LAST)
			begin
				next_cur.ctrl.output_valid = 1'b1;
			end
		end

		new_pd = {next_cur.word[dac_pd_pkg::PD_HI_BIT], next_cur.word[dac_pd_pkg::PD_LO_BIT]};
		if (next_cur.wr_commit)
		begin
			next_cur.ctrl.pwrdn_select_hi = new_pd[1];
			next_cur.ctrl.pwrdn_select_lo = new_pd[0];
			if (new_pd == dac_pd_pkg::PD_NORMAL)
			begin
				// code only follows the word in normal mode; powered down it stays frozen
				next_cur.ctrl.analog_output_level = next_cur.word[dac_pd_pkg::CODE_MSB:dac_pd_pkg::CODE_LSB];
				next_cur.ctrl.bias_en = 1'b1;
				next_cur.ctrl.amp_en = 1'b1;
				next_cur.ctrl.string_en = 1'b1;
				next_cur.ctrl.linear_en = 1'b1;
				next_cur.ctrl.term_high_z = 1'b0;
				next_cur.ctrl.term_2k5 = 1'b0;
				next_cur.ctrl.term_100k = 1'b0;
				if (!cur.ctrl.amp_en)
				begin
					next_cur.wake_cnt = dac_pd_pkg::WAKE_CNT_INIT;
					next_cur.ctrl.output_valid = 1'b0;
				end
			end
			else
			begin
				next_cur.ctrl.bias_en = 1'b0;
				next_cur.ctrl.amp_en = 1'b0;
				next_cur.ctrl.string_en = 1'b0;
				next_cur.ctrl.linear_en = 1'b0;
				next_cur.ctrl.output_valid = 1'b0;
				next_cur.wake_cnt = '0;
				next_cur.ctrl.term_high_z = (new_pd == dac_pd_pkg::PD_HIGH_Z);
				next_cur.ctrl.term_2k5 = (new_pd == dac_pd_pkg::PD_LOAD_2K5);
				next_cur.ctrl.term_100k = (new_pd == dac_pd_pkg::PD_LOAD_100K);
			end
		end
	end
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			cur <= dac_pd_pkg::CORE_RESET;
		end
		else
		begin
			cur <= next_cur;
		end
	end
	assign o_sda_out = cur.sda_out;
	assign o_sda_oe_n = cur.sda_oe_n;
	assign o_ctrl = cur.ctrl;
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);
	sequence wake_begin;
		$rose(cur.ctrl.amp_en);
	endsequence
	sequence wake_hold;
		(!cur.ctrl.output_valid) [*8];
	endsequence
	pd_entry_a: assert property (cur.wr_commit && (cur.word[13] || cur.word[12]) |-> !cur.ctrl.bias_en)
		else $error("power-down write left bias enabled");
	term_select_a: assert property ((cur.ctrl.pwrdn_select_hi || cur.ctrl.pwrdn_select_lo)
		== $onehot({cur.ctrl.term_high_z, cur.ctrl.term_2k5, cur.ctrl.term_100k}))
		else $error("termination select does not match mode");
	linear_off_a: assert property ((cur.ctrl.pwrdn_select_hi || cur.ctrl.pwrdn_select_lo)
		|-> !(cur.ctrl.bias_en || cur.ctrl.amp_en || cur.ctrl.string_en || cur.ctrl.linear_en))
		else $error("linear circuitry enabled in power-down");
	word_keep_a: assert property ($changed(cur.word) |-> cur.wr_commit)
		else $error("stored word changed without a write");
	read_word_a: assert property (cur.st == dac_pd_pkg::ST_RD_BYTE && $past(cur.st) == dac_pd_pkg::ST_ACK_ADDR
		|-> cur.shift == cur.word[15:8] && cur.sda_oe_n == cur.word[15])
		else $error("read did not start with stored upper byte");
	wake_code_a: assert property (cur.wr_commit && !cur.word[13] && !cur.word[12]
		|-> cur.ctrl.analog_output_level == cur.word[11:2] && cur.ctrl.amp_en)
		else $error("normal write did not load the code");
	wake_time_a: assert property (wake_begin |-> wake_hold ##1 wake_hold ##1 (!cur.ctrl.output_valid) [*4]
		##1 cur.ctrl.output_valid)
		else $error("wake-up interval wrong");
	sda_drive_a: assert property (!cur.sda_oe_n |-> cur.st inside {dac_pd_pkg::ST_ACK_ADDR,
		dac_pd_pkg::ST_ACK_WR, dac_pd_pkg::ST_RD_BYTE})
		else $error("data line driven outside own slots");
	mode_bits_a: assert property (cur.wr_commit |-> cur.ctrl.pwrdn_select_hi == cur.word[13]
		&& cur.ctrl.pwrdn_select_lo == cur.word[12])
		else $error("mode bits not taken from word");
	apply_ack_a: assert property (cur.wr_commit |-> cur.st == dac_pd_pkg::ST_ACK_WR && !cur.sda_oe_n
		&& $past(scl_rise))
		else $error("word applied outside lower-byte acknowledge");
endmodule
`default_nettype wire

// >>> dac_bus_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module dac_bus_ctrl_model (
	// clock
	input wire logic i_core_clk,
	// bus wires
	input wire logic i_sda,
	input wire logic i_dev_oe_n,
	output logic o_scl,
	output logic o_sda_rel
);
	int stray;

	initial
	begin
		o_scl = 1'b1;
		o_sda_rel = 1'b1;
		stray = 0;
	end

	task automatic wt(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask

	// data changes mid low phase so the device never sees it beside an scl edge
	task automatic bit_io(input logic b, input logic own, output logic r);
		o_sda_rel = b;
		wt(4);
		o_scl = 1'b1;
		wt(8);
		r = i_sda;
		if (own && i_dev_oe_n !== 1'b1)
			stray++;
		o_scl = 1'b0;
		wt(4);
	endtask

	task automatic byte_io(input logic [7:0] tx, input logic rd, input logic m_ack,
		output logic [7:0] rx, output logic s_ack);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(rd ? 1'b1 : tx[i], !rd, r);
			rx[i] = r;
		end
		bit_io(rd ? m_ack : 1'b1, rd, s_ack);
	endtask

	task automatic start;
		o_sda_rel = 1'b1;
		o_scl = 1'b1;
		wt(8);
		o_sda_rel = 1'b0;
		wt(8);
		o_scl = 1'b0;
		wt(4);
	endtask

	task automatic stop;
		o_sda_rel = 1'b0;
		wt(4);
		o_scl = 1'b1;
		wt(8);
		o_sda_rel = 1'b1;
		wt(8);
	endtask

	// nb below 2 leaves the word unsent or half sent, which the device must discard
	task automatic wr(input logic [6:0] addr, input logic [15:0] w, input int nb, output logic ok);
		logic [7:0] rx;
		logic a;
		start();
		byte_io({addr, 1'b0}, 1'b0, 1'b1, rx, a);
		ok = (a === 1'b0);
		if (nb > 0)
			byte_io(w[15:8], 1'b0, 1'b1, rx, a);
		if (nb > 1)
			byte_io(w[7:0], 1'b0, 1'b1, rx, a);
		stop();
	endtask

	task automatic rd(input logic [6:0] addr, output logic [15:0] w, output logic ok);
		logic a;
		logic [7:0] rx;
		start();
		byte_io({addr, 1'b1}, 1'b0, 1'b1, rx, a);
		ok = (a === 1'b0);
		byte_io(8'hff, 1'b1, 1'b0, w[15:8], a);
		byte_io(8'hff, 1'b1, 1'b1, w[7:0], a);
		stop();
	endtask
endmodule
`default_nettype wire

// >>> dac_power_down_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dac_power_down_control_tb;
	localparam logic [6:0] DEV_ADDR = 7'h2a;
	logic i_core_clk = 1'b0;
	logic i_rst = 1'b1;
	logic scl;
	logic sda_rel;
	logic o_sda_out;
	logic o_sda_oe_n;
	dac_pd_pkg::analog_ctrl_t o_ctrl;
	wire sda;
	int n_fail = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [7:0] wcnt = 8'h00;
	logic [7:0] wake_seen = 8'h00;
	logic amp_prev = 1'b1;
	logic valid_prev = 1'b1;
	logic [9:0] code_now = 10'h000;

	// pull-up on the wire
	assign sda = sda_rel & (o_sda_oe_n | o_sda_out);

	always #20 i_core_clk = ~i_core_clk;

	dac_power_down_control #(.SLAVE_ADDR(DEV_ADDR)) dut_u (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_scl(scl),
		.i_sda(sda),
		.o_sda_out(o_sda_out),
		.o_sda_oe_n(o_sda_oe_n),
		.o_ctrl(o_ctrl)
	);

	dac_bus_ctrl_model bus (
		.i_core_clk(i_core_clk),
		.i_sda(sda),
		.i_dev_oe_n(o_sda_oe_n),
		.o_scl(scl),
		.o_sda_rel(sda_rel)
	);

	// cycles from enables rising to the valid flag rising
	always @(negedge i_core_clk)
	begin
		amp_prev <= o_ctrl.amp_en;
		valid_prev <= o_ctrl.output_valid;
		wcnt <= (o_ctrl.amp_en && !amp_prev) ? 8'h00 : wcnt + 8'h01;
		if (o_ctrl.output_valid && !valid_prev)
			wake_seen <= wcnt + 8'h01;
	end

	always @(posedge i_core_clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			n_fail++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check_ctrl(input string name, input dac_pd_pkg::analog_ctrl_t exp);
		total_checks++;
		if (o_ctrl !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, o_ctrl);
		end
	endtask

	function automatic dac_pd_pkg::analog_ctrl_t exp_ctrl(input logic [1:0] md, input logic [9:0] code,
		input logic valid);
		dac_pd_pkg::analog_ctrl_t c;
		c.analog_output_level = code;
		{c.pwrdn_select_hi, c.pwrdn_select_lo} = md;
		c.bias_en = (md == 2'h0);
		c.amp_en = (md == 2'h0);
		c.string_en = (md == 2'h0);
		c.linear_en = (md == 2'h0);
		c.term_high_z = (md == 2'h3);
		c.term_2k5 = (md == 2'h1);
		c.term_100k = (md == 2'h2);
		c.output_valid = valid;
		return c;
	endfunction

	task automatic t_reset;
		logic [15:0] w;
		logic ok;
		check_ctrl("reset ctrl", exp_ctrl(2'h0, 10'h000, 1'b1));
		bus.rd(DEV_ADDR, w, ok);
		check_val("reset ack", 16'h0001, {15'h0, ok});
		check_val("reset word", 16'h0000, w);
	endtask

	task automatic t_normal;
		logic [15:0] w;
		logic ok;
		bus.wr(DEV_ADDR, {4'h0, 10'h2a5, 2'h2}, 2, ok);
		code_now = 10'h2a5;
		check_val("normal ack", 16'h0001, {15'h0, ok});
		check_ctrl("normal ctrl", exp_ctrl(2'h0, code_now, 1'b1));
		// half word and foreign address must leave everything alone
		bus.wr(DEV_ADDR, {4'h3, 10'h111, 2'h0}, 1, ok);
		check_ctrl("half word", exp_ctrl(2'h0, code_now, 1'b1));
		bus.wr(7'h15, {4'h3, 10'h111, 2'h0}, 2, ok);
		check_val("foreign ack", 16'h0000, {15'h0, ok});
		check_ctrl("foreign ctrl", exp_ctrl(2'h0, code_now, 1'b1));
		// broadcast is write only: a read there must find the line released
		bus.rd(dac_pd_pkg::BROADCAST_ADDR, w, ok);
		check_val("broadcast read ack", 16'h0000, {15'h0, ok});
		check_val("broadcast read data", 16'hffff, w);
	endtask

	task automatic t_modes;
		logic [15:0] w;
		logic [15:0] r;
		logic ok;
		for (int m = 1; m <= 3; m++)
		begin
			w = {2'h0, 2'(m), 10'h0f0 + 10'(m), 2'h1};
			bus.wr((m == 2) ? dac_pd_pkg::BROADCAST_ADDR : DEV_ADDR, w, 2, ok);
			check_val("pd ack", 16'h0001, {15'h0, ok});
			check_ctrl("pd ctrl", exp_ctrl(2'(m), code_now, 1'b0));
			bus.rd(DEV_ADDR, r, ok);
			check_val("pd readback", w, r);
		end
	endtask

	task automatic t_wake;
		logic ok;
		bus.wr(DEV_ADDR, {4'h0, 10'h3c3, 2'h0}, 2, ok);
		code_now = 10'h3c3;
		check_ctrl("wake ctrl", exp_ctrl(2'h0, code_now, 1'b1));
		check_val("wake cycles", 16'(dac_pd_pkg::WAKE_CYCLES), {8'h00, wake_seen});
		check_val("stray drive", 16'h0000, 16'(bus.stray));
	endtask

	// reset from a powered-down state must clear word, mode and code
	task automatic t_mid_reset;
		logic [15:0] w;
		logic ok;
		bus.wr(DEV_ADDR, {4'h1, 10'h155, 2'h3}, 2, ok);
		check_ctrl("pre reset ctrl", exp_ctrl(2'h1, code_now, 1'b0));
		i_rst = 1'b1;
		repeat (20) @(negedge i_core_clk);
		i_rst = 1'b0;
		repeat (4) @(negedge i_core_clk);
		check_ctrl("rerun ctrl", exp_ctrl(2'h0, 10'h000, 1'b1));
		bus.rd(DEV_ADDR, w, ok);
		check_val("rerun ack", 16'h0001, {15'h0, ok});
		check_val("rerun word", 16'h0000, w);
	endtask

	initial
	begin
		repeat (20) @(negedge i_core_clk);
		i_rst = 1'b0;
		repeat (4) @(negedge i_core_clk);
		t_reset();
		t_normal();
		t_modes();
		t_wake();
		t_mid_reset();
		tally_and_finish();
	end
endmodule
`default_nettype wire
